//--- logic/rcs_pkg.sv
package rcs_pkg;
  // clock and timing
  localparam int CLK_NS = 25;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYC_DEF = SEC_NS / CLK_NS;
  localparam int SHUTOFF_RESP_NS = 2_000_000;
  localparam int SHUTOFF_RESP_CYC = SHUTOFF_RESP_NS / CLK_NS;
  localparam int OTHER_RESP_NS = 20_000_000;
  localparam int OTHER_RESP_CYC = OTHER_RESP_NS / CLK_NS;

  // register byte addresses
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_STOP = 8'h04;
  localparam logic [7:0] ADR_EXT = 8'h08;
  localparam logic [7:0] ADR_COMM = 8'h0C;
  localparam logic [7:0] ADR_ASSIGN = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;

  // shutoff logic selections
  localparam logic [2:0] SEL_NO = 3'h0;
  localparam logic [2:0] SEL_NC = 3'h2;
  localparam logic [2:0] SEL_MIX = 3'h4;

  // stop method settings
  localparam logic [13:0] STOP_RAMP_DIR = 14'h270F;
  localparam logic [13:0] STOP_RAMP_START = 14'h22B8;
  localparam logic [13:0] STOP_TIMED_MAX = 14'h0064;
  localparam logic [13:0] STOP_OFS = 14'h03E8;
  localparam logic [13:0] STOP_OFS_MAX = 14'h044C;

  localparam logic [15:0] EXT_UNLOCK = 16'h0000;
  localparam logic [15:0] EXT_RESET = 16'h0000;
  localparam logic [7:0] CODE_SHUTOFF = 8'h18;
  localparam logic [7:0] CODE_SECOND = 8'h03;

  // status bit positions
  localparam int STS_RUN = 0;
  localparam int STS_REV = 1;
  localparam int STS_DECEL = 2;
  localparam int STS_SHUTOFF = 3;
  localparam int STS_SECOND = 4;

  // first and second set parameter numbers
  localparam logic [9:0] PAR_BOOST1 = 10'h000;
  localparam logic [9:0] PAR_BOOST2 = 10'h02E;
  localparam logic [9:0] PAR_BASE1 = 10'h003;
  localparam logic [9:0] PAR_BASE2 = 10'h02F;
  localparam logic [9:0] PAR_ACC1 = 10'h007;
  localparam logic [9:0] PAR_ACC2 = 10'h02C;
  localparam logic [9:0] PAR_DEC1 = 10'h008;
  localparam logic [9:0] PAR_DEC2 = 10'h02D;
  localparam logic [9:0] PAR_THERM1 = 10'h009;
  localparam logic [9:0] PAR_THERM2 = 10'h033;
  localparam logic [9:0] PAR_STALL1 = 10'h016;
  localparam logic [9:0] PAR_STALL2 = 10'h030;
  localparam logic [9:0] PAR_MOTOR1 = 10'h047;
  localparam logic [9:0] PAR_MOTOR2 = 10'h1C2;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} rcs_run_t;
endpackage

//--- logic/rcs_sync.sv
`timescale 1ns/1ps
module rcs_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // rcs_sync

//--- logic/rcs_run_ctrl.sv
// Notes on behaviour
// R1 - shutoff input active while running cuts motor output at once
// R2 - shutoff acts only on a terminal assigned function code 24
// R3 - selection 0 normally open, 2 normally closed, 4 terminal NC and link NO
// R4 - sel 0 runs with both sources off; sel 2 with both on
// R5 - sel 4 runs only with terminal on and link source off
// R6 - no start while shutoff active, even with a start input
// R7 - shutoff makes the motor coast, not ramp down
// R8 - shutoff works in panel, terminal and network modes alike
// R9 - code 3 input switches all second-set parameters together
// R10 - second set substitutes 46,47,44,45,51,48,450 for 0,3,7,8,9,22,71
// R11 - setting 9999: direction starts, release ramps down to stop
// R12 - setting 0..100 s: coast after that time from release
// R13 - setting 1000..1100 s: coast after setting minus 1000 s
// R14 - 8888 or 1000..1100: forward is start, reverse picks direction
// R15 - direction starts: both off or both on ramps to stop
// R16 - shutoff selection and stop method writable only with enable 0
// R17 - shutoff acts within 2 ms, other inputs within 20 ms
// R18 - synchronise pins, apply polarity, then combine shutoff sources
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module rcs_run_ctrl
  import rcs_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYC_DEF,
  parameter int RESP_CYC = SHUTOFF_RESP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic output_shutoff_input_i,
  input wire logic second_set_select_input_i,
  input wire logic forward_start_input_i,
  input wire logic reverse_start_input_i,
  input wire logic decel_done_i,
  input wire logic [9:0] par_query_i,
  output logic motor_enable_o,
  output logic run_cmd_o,
  output logic reverse_o,
  output logic ramp_stop_o,
  output logic coast_o,
  output logic second_set_o,
  output logic [9:0] par_active_o
);
  localparam int DW = $clog2(SEC_CYC + 1);

  logic [3:0] pin_s;
  logic [2:0] sel_reg;
  logic [13:0] stop_reg;
  logic [15:0] ext_reg;
  logic comm_reg;
  logic [7:0] asg_mrs_reg;
  logic [7:0] asg_rt_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  rcs_run_t state_reg;
  rcs_run_t state_next;
  logic coast_ev;
  logic [DW-1:0] div_reg;
  logic [6:0] tmr_reg;
  logic rev_reg;
  logic coast_reg;
  logic second_reg;
  logic [9:0] par_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [9:0] par_map(input logic [9:0] q);
    logic [9:0] r;
    r = q;
    unique case (q)
      PAR_BOOST1: r = PAR_BOOST2;
      PAR_BASE1: r = PAR_BASE2;
      PAR_ACC1: r = PAR_ACC2;
      PAR_DEC1: r = PAR_DEC2;
      PAR_THERM1: r = PAR_THERM2;
      PAR_STALL1: r = PAR_STALL2;
      PAR_MOTOR1: r = PAR_MOTOR2;
      default: r = q;
    endcase
    return r;
  endfunction

  // R17 two-flop pin path, well inside both response times
  // R18 pins synchronised before any decode
  rcs_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({reverse_start_input_i, forward_start_input_i,
          second_set_select_input_i, output_shutoff_input_i}),
    .q_o(pin_s)
  );

  wire pin_mrs = pin_s[0];
  wire pin_rt = pin_s[1];
  wire pin_fwd = pin_s[2];
  wire pin_rev = pin_s[3];

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr = bus_req & wb_we_i;
  wire hit_cfg = wb_adr_i == ADR_CFG;
  wire hit_stop = wb_adr_i == ADR_STOP;
  wire hit_ext = wb_adr_i == ADR_EXT;
  wire hit_comm = wb_adr_i == ADR_COMM;
  wire hit_asg = wb_adr_i == ADR_ASSIGN;
  wire hit_sts = wb_adr_i == ADR_STATUS;
  wire unlocked = ext_reg == EXT_UNLOCK;

  wire [31:0] cfg_w = merge({29'h0, sel_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] stop_w = merge({18'h0, stop_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] ext_w = merge({16'h0, ext_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] comm_w = merge({31'h0, comm_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] asg_w = merge({16'h0, asg_rt_reg, asg_mrs_reg}, wb_dat_i, wb_sel_i);
  wire [13:0] stop_f = stop_w[13:0];
  wire sel_ok = (cfg_w[31:3] == 29'h0) &&
                (cfg_w[2:0] == SEL_NO || cfg_w[2:0] == SEL_NC || cfg_w[2:0] == SEL_MIX);
  wire stop_ok = (stop_w[31:14] == 18'h0) &&
                 (stop_f <= STOP_TIMED_MAX || (stop_f >= STOP_OFS && stop_f <= STOP_OFS_MAX) ||
                  stop_f == STOP_RAMP_DIR || stop_f == STOP_RAMP_START);
  // R16 locked settings and illegal codes are dropped silently
  wire cfg_we = bus_wr & hit_cfg & unlocked & sel_ok;
  wire stop_we = bus_wr & hit_stop & unlocked & stop_ok;

  // R2 unassigned terminal rests at its run level
  // R3 terminal polarity applied before combining
  wire term_on = (asg_mrs_reg == CODE_SHUTOFF) ? pin_mrs : (sel_reg != SEL_NO);
  // R4 both-off or both-on enable
  // R5 terminal on and link off enable
  // R8 no operation mode term: shutoff is mode independent
  wire op_enable = (sel_reg == SEL_NC) ? (term_on & comm_reg) :
                   (sel_reg == SEL_MIX) ? (term_on & ~comm_reg) :
                   (~term_on & ~comm_reg);

  // R9 one signal swaps the whole set
  wire rt_on = (asg_rt_reg == CODE_SECOND) & pin_rt;

  // R11 R12 direction-start settings
  wire dir_mode = stop_reg <= STOP_TIMED_MAX || stop_reg == STOP_RAMP_DIR;
  wire timed = stop_reg <= STOP_TIMED_MAX ||
               (stop_reg >= STOP_OFS && stop_reg <= STOP_OFS_MAX);
  // R13 delay offset removed
  wire [13:0] ofs_d = stop_reg - STOP_OFS;
  wire [6:0] delay_s = (stop_reg <= STOP_TIMED_MAX) ? stop_reg[6:0] : ofs_d[6:0];
  // R14 forward starts, reverse picks direction
  // R15 exclusive direction inputs
  wire start_cmd = dir_mode ? (pin_fwd ^ pin_rev) : pin_fwd;
  wire sec_end = div_reg == DW'(SEC_CYC - 1);
  wire timer_hit = sec_end && (tmr_reg == 7'h01);

  wire [31:0] sts_w = {27'h0, second_reg, ~op_enable, ramp_stop_o, rev_reg, run_cmd_o};
  wire [31:0] rd_mux = hit_cfg ? {29'h0, sel_reg} :
                       hit_stop ? {18'h0, stop_reg} :
                       hit_ext ? {16'h0, ext_reg} :
                       hit_comm ? {31'h0, comm_reg} :
                       hit_asg ? {16'h0, asg_rt_reg, asg_mrs_reg} :
                       hit_sts ? sts_w : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_mux : dat_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= SEL_NO;
      stop_reg <= STOP_RAMP_DIR;
      ext_reg <= EXT_RESET;
      comm_reg <= 1'b0;
      asg_mrs_reg <= CODE_SHUTOFF;
      asg_rt_reg <= CODE_SECOND;
    end else begin
      if (cfg_we) sel_reg <= cfg_w[2:0];
      if (stop_we) stop_reg <= stop_f;
      if (bus_wr && hit_ext) ext_reg <= ext_w[15:0];
      if (bus_wr && hit_comm) comm_reg <= comm_w[0];
      if (bus_wr && hit_asg) {asg_rt_reg, asg_mrs_reg} <= asg_w[15:0];
    end
  end

  always_comb begin
    state_next = state_reg;
    coast_ev = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // R6 start refused while shut off
        if (op_enable && start_cmd) state_next = ST_RUN;
      end
      ST_RUN: begin
        // R1 R7 shutoff drops output, motor coasts
        if (!op_enable) begin
          state_next = ST_IDLE;
          coast_ev = 1'b1;
        end else if (!start_cmd) begin
          // R12 zero delay coasts at once
          state_next = (timed && delay_s == 7'h00) ? ST_IDLE : ST_DECEL;
          coast_ev = timed && delay_s == 7'h00;
        end
      end
      ST_DECEL: begin
        if (!op_enable) begin
          state_next = ST_IDLE;
          coast_ev = 1'b1;
        end else if (start_cmd) begin
          state_next = ST_RUN;
        end else if (decel_done_i) begin
          state_next = ST_IDLE;
        end else if (timed && timer_hit) begin
          // R12 R13 time up, let it coast
          state_next = ST_IDLE;
          coast_ev = 1'b1;
        end
      end
    endcase
  end

  // whole-second timer restarts on each release so the delay is never short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= '0;
      tmr_reg <= 7'h00;
    end else if (state_reg != ST_DECEL) begin
      div_reg <= '0;
      tmr_reg <= delay_s;
    end else begin
      div_reg <= sec_end ? '0 : div_reg + 1'b1;
      tmr_reg <= sec_end ? tmr_reg - 7'h01 : tmr_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      rev_reg <= 1'b0;
      coast_reg <= 1'b0;
      second_reg <= 1'b0;
      par_reg <= PAR_BOOST1;
    end else begin
      state_reg <= state_next;
      // R14 R15 direction latched while the start holds
      if (state_next == ST_RUN) rev_reg <= pin_rev;
      coast_reg <= coast_ev;
      second_reg <= rt_on;
      // R10 substitute lookup
      par_reg <= rt_on ? par_map(par_query_i) : par_query_i;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign motor_enable_o = state_reg != ST_IDLE;
  assign run_cmd_o = state_reg == ST_RUN;
  assign ramp_stop_o = state_reg == ST_DECEL;
  assign reverse_o = rev_reg;
  assign coast_o = coast_reg;
  assign second_set_o = second_reg;
  assign par_active_o = par_reg;

  // helper: cycles the output stays on after shutoff asked for it
  int resp_lag;
  always_ff @(posedge clk_i) begin
    if (rst_i) resp_lag <= 0;
    else resp_lag <= (motor_enable_o && !op_enable) ? resp_lag + 1 : 0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_release;
    state_reg == ST_RUN && op_enable && !start_cmd && stop_reg == STOP_RAMP_DIR;
  endsequence
  sequence s_ramp_hold;
    ramp_stop_o && !coast_o && motor_enable_o;
  endsequence

  a_shutoff_cuts_out: assert property (!op_enable |=> !motor_enable_o && !run_cmd_o) // R1
    else $error("output still on under shutoff");
  a_nc_open_stops: assert property ((sel_reg == SEL_NC && asg_mrs_reg == CODE_SHUTOFF && !pin_mrs)
    |-> ##1 !motor_enable_o) // R3
    else $error("open contact did not stop output");
  a_no_both_off: assert property ((sel_reg == SEL_NO && asg_mrs_reg == CODE_SHUTOFF
    && !pin_mrs && !comm_reg && state_reg == ST_IDLE && start_cmd) |=> run_cmd_o) // R4
    else $error("enabled start refused");
  a_mix_link_blocks: assert property ((sel_reg == SEL_MIX && comm_reg) |=> !motor_enable_o) // R5
    else $error("link shutoff ignored");
  a_start_interlock: assert property ((!op_enable && state_reg == ST_IDLE && start_cmd)
    |=> state_reg == ST_IDLE) // R6
    else $error("started while shut off");
  a_shutoff_coasts: assert property ((state_reg != ST_IDLE && !op_enable)
    |=> coast_o && !ramp_stop_o) // R7
    else $error("shutoff did not coast");
  a_second_set_map: assert property ((rt_on && par_query_i == PAR_MOTOR1)
    |=> second_set_o && par_active_o == PAR_MOTOR2) // R9
    else $error("second set not applied");
  a_first_set_keep: assert property ((!rt_on && par_query_i == PAR_DEC1)
    |=> !second_set_o && par_active_o == PAR_DEC1) // R10
    else $error("first set replaced");
  a_release_ramps: assert property (s_run_release ##1 (!decel_done_i && !start_cmd && op_enable)
    |=> s_ramp_hold) // R11
    else $error("release did not ramp");
  a_ramp_end_idle: assert property ((ramp_stop_o && op_enable && !start_cmd && decel_done_i)
    |=> !motor_enable_o && !coast_o) // R11
    else $error("finished ramp kept output on");
  a_timed_zero_coast: assert property ((state_reg == ST_RUN && op_enable && !start_cmd
    && stop_reg == 14'h0000) |=> coast_o && !motor_enable_o) // R12
    else $error("zero delay did not coast");
  a_offset_timer_load: assert property ((state_reg == ST_RUN && state_next == ST_DECEL
    && stop_reg >= STOP_OFS && stop_reg <= STOP_OFS_MAX)
    |=> tmr_reg == 7'(stop_reg - STOP_OFS)) // R13
    else $error("coast delay wrong");
  a_start_dir_sel: assert property ((state_reg == ST_IDLE && op_enable
    && stop_reg == STOP_RAMP_START && pin_fwd && pin_rev) |=> run_cmd_o && reverse_o) // R14
    else $error("reverse select failed");
  a_both_on_stops: assert property ((state_reg == ST_RUN && op_enable && dir_mode
    && pin_fwd && pin_rev) |=> !run_cmd_o) // R15
    else $error("both starts kept running");
  a_locked_write: assert property ((bus_wr && (hit_cfg || hit_stop) && !unlocked)
    |=> $stable(sel_reg) && $stable(stop_reg)) // R16
    else $error("locked setting changed");
  a_resp_bound: assert property (resp_lag < RESP_CYC) // R17
    else $error("shutoff response too slow");
endmodule // rcs_run_ctrl

//--- tb/rcs_contacts.sv
`timescale 1ns/1ps
module rcs_contacts (
  input wire logic clk_i,
  input wire logic [3:0] want_i,
  input wire logic fast_i,
  input wire logic ramp_i,
  output logic [3:0] pin_o = 4'h0,
  output logic done_o = 1'b0
);
  logic [2:0] cnt_reg = 3'h0;
  // a slow load never reaches zero speed, so only a coast can end its ramp
  always @(posedge clk_i) begin
    pin_o <= want_i;
    cnt_reg <= ramp_i ? cnt_reg + ((cnt_reg != 3'h7) ? 3'h1 : 3'h0) : 3'h0;
    done_o <= fast_i && ramp_i && (cnt_reg >= 3'h3);
  end
endmodule // rcs_contacts

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import rcs_pkg::*;
  localparam int SC = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack;
  logic [3:0] want = 4'h0;
  logic [3:0] pin;
  logic fast = 1'b0;
  logic done, men, run, rev, ramp, coast, sec;
  logic [9:0] q = 10'h000;
  logic [9:0] pact;
  logic [31:0] st = 32'h933770A2;
  logic [9:0] firsts [7] = '{PAR_BOOST1, PAR_BASE1, PAR_ACC1, PAR_DEC1,
    PAR_THERM1, PAR_STALL1, PAR_MOTOR1};
  logic [2:0] sels [3] = '{SEL_NO, SEL_NC, SEL_MIX};
  int error_cnt = 0;
  int check_count = 0;
  int coast_n = 0;
  int n0;

  rcs_run_ctrl #(.SEC_CYC(SC)) rcs_run_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .output_shutoff_input_i(pin[0]),
    .second_set_select_input_i(pin[1]), .forward_start_input_i(pin[2]),
    .reverse_start_input_i(pin[3]), .decel_done_i(done), .par_query_i(q),
    .motor_enable_o(men), .run_cmd_o(run), .reverse_o(rev), .ramp_stop_o(ramp),
    .coast_o(coast), .second_set_o(sec), .par_active_o(pact));
  rcs_contacts rcs_contacts_inst (.clk_i(clk_i), .want_i(want), .fast_i(fast),
    .ramp_i(ramp), .pin_o(pin), .done_o(done));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (coast === 1'b1) coast_n++;
  end

  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  function automatic logic [9:0] pmap(input logic s, input logic [9:0] p);
    if (!s) return p;
    case (p)
      PAR_BOOST1: return PAR_BOOST2;
      PAR_BASE1: return PAR_BASE2;
      PAR_ACC1: return PAR_ACC2;
      PAR_DEC1: return PAR_DEC2;
      PAR_THERM1: return PAR_THERM2;
      PAR_STALL1: return PAR_STALL2;
      PAR_MOTOR1: return PAR_MOTOR2;
      default: return p;
    endcase
  endfunction
  function automatic logic en_exp(input logic [2:0] s, input logic t, input logic c);
    case (s)
      SEL_NO: return !t && !c;
      SEL_NC: return t && c;
      default: return t && !c;
    endcase
  endfunction

  task automatic results();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bound(input int i);
    if (i >= 100) begin
      error_cnt++;
      $display("ERROR t=%0t wait cycles got=%h limit=%h", $time, i, 100);
      results();
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lvl(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t level got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_end(input string name);
    $display("test %s done at %0t", name, $time);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 100 && ack !== 1'b1; i++) @(posedge clk_i);
    bound(i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic pins(input logic [3:0] w);
    @(posedge clk_i);
    want <= w;
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 100 && men !== 1'b0; i++) @(posedge clk_i);
    bound(i);
    #1;
  endtask
  task automatic pq(input logic s, input logic [9:0] v);
    @(posedge clk_i);
    q <= v;
    @(posedge clk_i);
    #1;
    chk_val({22'h0, pact}, {22'h0, pmap(s, v)});
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_STOP, 32'h0);
    chk_val(rdat, 32'h0000270F);
    wb(1'b0, ADR_ASSIGN, 32'h0);
    chk_val(rdat, 32'h00000318);
    wb(1'b0, 8'h20, 32'h0);
    chk_val(rdat, 32'h0);
    test_end("reset");
    pins(4'h4);
    chk_lvl(run, 1'b1);
    chk_lvl(rev, 1'b0);
    pins(4'hC);
    chk_lvl(ramp, 1'b1);
    pins(4'h8);
    chk_lvl(run, 1'b1);
    chk_lvl(rev, 1'b1);
    n0 = coast_n;
    pins(4'h0);
    chk_lvl(ramp, 1'b1);
    fast = 1'b1;
    wait_idle();
    chk_val(coast_n, n0);
    test_end("direction");
    wb(1'b1, ADR_STOP, 32'h000022B8);
    pins(4'h8);
    chk_lvl(men, 1'b0);
    pins(4'hC);
    chk_lvl(rev, 1'b1);
    chk_lvl(run, 1'b1);
    pins(4'h0);
    wait_idle();
    test_end("start_mode");
    fast = 1'b0;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, ADR_STOP, k ? 32'd1001 : 32'd2);
      pins(4'h4);
      n0 = coast_n;
      pins(4'h0);
      chk_lvl(ramp, 1'b1);
      repeat ((2 - k) * SC - 8) @(posedge clk_i);
      #1;
      chk_lvl(men, 1'b1);
      wait_idle();
      chk_val(coast_n, n0 + 1);
    end
    // zero delay in both timed ranges coasts straight from run after release, with no ramp and one coast pulse
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, ADR_STOP, k ? 32'd1000 : 32'd0);
      pins(4'h4);
      n0 = coast_n;
      pins(4'h0);
      chk_lvl(men, 1'b0);
      chk_lvl(ramp, 1'b0);
      chk_val(coast_n, n0 + 1);
    end
    test_end("timed");
    fast = 1'b1;
    wb(1'b1, ADR_STOP, 32'h0000270F);
    for (int i = 0; i < 12; i++) begin
      wb(1'b1, ADR_CFG, {29'h0, sels[i / 4]});
      wb(1'b1, ADR_COMM, {31'h0, i[1]});
      pins({3'b010, i[0]});
      chk_lvl(men, en_exp(sels[i / 4], i[0], i[1]));
      pins({3'b000, i[0]});
      wait_idle();
    end
    test_end("shutoff_table");
    wb(1'b1, ADR_CFG, 32'h0);
    wb(1'b1, ADR_COMM, 32'h0);
    pins(4'h4);
    n0 = coast_n;
    pins(4'h5);
    chk_lvl(men, 1'b0);
    chk_lvl(ramp, 1'b0);
    chk_val(coast_n, n0 + 1);
    pins(4'h0);
    wb(1'b1, ADR_EXT, 32'h1);
    wb(1'b1, ADR_CFG, 32'h2);
    wb(1'b1, ADR_STOP, 32'h000022B8);
    wb(1'b0, ADR_CFG, 32'h0);
    chk_val(rdat, 32'h0);
    wb(1'b0, ADR_STOP, 32'h0);
    chk_val(rdat, 32'h0000270F);
    wb(1'b1, ADR_EXT, 32'h0);
    wb(1'b1, ADR_ASSIGN, 32'h00000319);
    pins(4'h5);
    chk_lvl(men, 1'b1);
    pins(4'h0);
    wait_idle();
    wb(1'b1, ADR_ASSIGN, 32'h00000318);
    test_end("interlock");
    for (int s = 1; s >= 0; s--) begin
      pins({2'b00, s[0], 1'b0});
      chk_lvl(sec, s[0]);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk_val(rdat, s ? 32'h10 : 32'h0);
      for (int j = 0; j < 14; j++) pq(s[0], st[0] ? firsts[j % 7] : xs());
    end
    test_end("second_set");
    results();
  end
endmodule // tb
